// ===== logic/serial_rate_pkg.sv
// Constants, field layouts and carriers for the serial host link and its rate generator.
// Assumes one 200 MHz bus clock, AHB-Lite register access and a 27.12 MHz crystal rate.
//
// Behaviour
// - With a zero exponent the bit rate is the 27.12 MHz crystal rate divided by (divisor + 1).
// - With a nonzero exponent the crystal rate is divided by (divisor + 33), then by 2 to the (exponent - 1).
// - The rate setting register holds the 3-bit exponent in bits 7..5 and the 5-bit divisor in bits 4..0.
// - Every character is one start bit, eight data bits and one stop bit, with no parity, both ways.
// - After reset the rate setting register holds 7a, which is 115.2 kbit/s.
// - The standard rates map to fixed codes, such as 7a for 115.2 kbit/s and 15 for 1228.8 kbit/s.
package serial_rate_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_KHZ = 200000;
	localparam int XTAL_KHZ = 27120;
	localparam int RATE_GCD = 80;
	localparam int XTAL_INC = XTAL_KHZ / RATE_GCD;
	localparam int XTAL_MOD = CLK_KHZ / RATE_GCD;
	localparam int PHASE_W = 12;
	localparam int PERIOD_W = 13;
	localparam int DIV_BASE_EXP0 = 1;
	localparam int DIV_BASE_EXPN = 33;
	localparam int DATA_BITS = 8;
	localparam int FRAME_BIT_ENDS = 9;
	localparam int FIFO_DEPTH = 4;
	localparam logic [PERIOD_W-1:0] PERIOD_ONE = 13'h1;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int RATE_IDX = 'h3b;
	localparam logic [7:0] RATE_ADDR = 8'(RATE_IDX * 4);
	localparam logic [7:0] TX_ADDR = 8'h00;
	localparam logic [7:0] RX_ADDR = 8'h04;
	localparam logic [7:0] STAT_ADDR = 8'h08;
	localparam logic [7:0] RATE_RESET = 8'h7a;
	localparam int PERIOD_RESET = (int'(RATE_RESET[4:0]) + DIV_BASE_EXPN) << (int'(RATE_RESET[7:5]) - 1);
	localparam int ST_RX_VALID = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_FRAME_ERR = 2;
	localparam int ST_TX_FULL = 3;
	localparam int ST_TX_BUSY = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] rate_exponent;
		logic [4:0] rate_divisor;
	} rate_setting_t;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic valid;
	} bus_phase_t;

	typedef enum logic [1:0] {LINE_IDLE, LINE_START, LINE_DATA, LINE_STOP} line_state_t;

endpackage

// ===== logic/serial_host_link.sv
// Serial host link: AHB-Lite register slave, crystal-rate bit timing, transmit FIFO, transmitter, receiver.
// Assumes a 200 MHz hclk, a single AHB-Lite master and an asynchronous rxd pin.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module serial_tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + (AW+1)'(1);
		end else if (pop && !push) begin
			count <= count - (AW+1)'(1);
		end
	end
endmodule // serial_tx_fifo

// ----------------------------------------
// Link top
// ----------------------------------------
module serial_host_link #(
	parameter int FIFO_DEPTH = serial_rate_pkg::FIFO_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rxd,
	output logic txd
);
	localparam int PW = serial_rate_pkg::PERIOD_W;

	logic [serial_rate_pkg::PHASE_W-1:0] phase;
	logic xtal_tick;
	serial_rate_pkg::rate_setting_t rate;
	logic [PW-1:0] period;
	serial_rate_pkg::bus_phase_t dph;
	logic accept;
	logic wr_done;
	logic rx_read;
	logic stat_write;
	logic [31:0] status;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	serial_rate_pkg::line_state_t tx_state;
	logic [PW-1:0] tx_cnt;
	logic [2:0] tx_bit;
	logic [7:0] tx_shift;
	logic tx_bit_end;
	logic [3:0] frame_bits;
	logic rx_meta;
	logic rx_sync;
	serial_rate_pkg::line_state_t rx_state;
	logic [PW-1:0] rx_cnt;
	logic [2:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_step;
	logic rx_done;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_overrun;
	logic rx_frame_err;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ----------------------------------------
	// Crystal-rate tick from the bus clock
	// ----------------------------------------
	// Fractional accumulator: one tick per 27.12 MHz crystal period on average
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= '0;
			xtal_tick <= 1'h0;
		end else if (int'(phase) + serial_rate_pkg::XTAL_INC >= serial_rate_pkg::XTAL_MOD) begin
			phase <= serial_rate_pkg::PHASE_W'(int'(phase) + serial_rate_pkg::XTAL_INC - serial_rate_pkg::XTAL_MOD);
			xtal_tick <= 1'h1;
		end else begin
			phase <= serial_rate_pkg::PHASE_W'(int'(phase) + serial_rate_pkg::XTAL_INC);
			xtal_tick <= 1'h0;
		end
	end

	tick_spacing_a: assert property (xtal_tick |=> (!xtal_tick) [*6] ##[1:2] xtal_tick)
		else $error("crystal tick spacing wrong");

	// ----------------------------------------
	// Rate setting and bit period
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate <= serial_rate_pkg::RATE_RESET;
		end else if (wr_done && dph.addr == serial_rate_pkg::RATE_ADDR) begin
			rate <= serial_rate_pkg::rate_setting_t'(hwdata[7:0]);
		end
	end

	// Bit period in crystal ticks; the standard codes fall out of this formula
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period <= PW'(serial_rate_pkg::PERIOD_RESET);
		end else if (rate.rate_exponent == 3'h0) begin
			period <= PW'(int'(rate.rate_divisor) + serial_rate_pkg::DIV_BASE_EXP0);
		end else begin
			period <= PW'((int'(rate.rate_divisor) + serial_rate_pkg::DIV_BASE_EXPN)
				<< (int'(rate.rate_exponent) - 1));
		end
	end

	rate_reset_a: assert property (!$past(hresetn) |-> rate == serial_rate_pkg::RATE_RESET)
		else $error("rate setting not at reset value");
	rate_write_a: assert property (wr_done && dph.addr == serial_rate_pkg::RATE_ADDR
		|=> rate == serial_rate_pkg::rate_setting_t'($past(hwdata[7:0])))
		else $error("rate write not taken");
	period_exp0_a: assert property ($stable(rate) && rate.rate_exponent == 3'h0
		|-> int'(period) == int'(rate.rate_divisor) + 1)
		else $error("period wrong for zero exponent");
	period_expn_a: assert property ($stable(rate) && rate.rate_exponent != 3'h0
		|-> int'(period) == ((int'(rate.rate_divisor) + 33) << (int'(rate.rate_exponent) - 1)))
		else $error("period wrong for nonzero exponent");

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign accept = hsel && htrans[1] && hready;
	assign wr_done = dph.valid && dph.write && hready;
	assign rx_read = accept && !hwrite && haddr[7:0] == serial_rate_pkg::RX_ADDR;
	assign stat_write = wr_done && dph.addr == serial_rate_pkg::STAT_ADDR;
	assign fifo_in_valid = wr_done && dph.addr == serial_rate_pkg::TX_ADDR;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph <= '0;
		end else if (hready) begin
			dph.valid <= accept;
			dph.addr <= haddr[7:0];
			dph.write <= hwrite;
		end
	end

	// Transmit writes wait at least one cycle, then until the FIFO has room
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'h1;
		end else if (accept && hwrite && haddr[7:0] == serial_rate_pkg::TX_ADDR) begin
			hreadyout <= 1'h0;
		end else if (!hreadyout) begin
			hreadyout <= fifo_in_ready;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'h0;
		end else begin
			hresp <= 1'h0;
		end
	end

	always_comb begin
		status = '0;
		status[serial_rate_pkg::ST_RX_VALID] = rx_valid;
		status[serial_rate_pkg::ST_OVERRUN] = rx_overrun;
		status[serial_rate_pkg::ST_FRAME_ERR] = rx_frame_err;
		status[serial_rate_pkg::ST_TX_FULL] = !fifo_in_ready;
		status[serial_rate_pkg::ST_TX_BUSY] = fifo_out_valid || tx_state != serial_rate_pkg::LINE_IDLE;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (accept && !hwrite) begin
			case (haddr[7:0])
				serial_rate_pkg::RATE_ADDR: hrdata <= {24'h0, rate};
				serial_rate_pkg::RX_ADDR: hrdata <= {24'h0, rx_data};
				serial_rate_pkg::STAT_ADDR: hrdata <= status;
				default: hrdata <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	serial_tx_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) tx_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(hwdata[7:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Frames start on a crystal tick, so the start bit lasts a whole period like the others
	assign fifo_out_ready = (tx_state == serial_rate_pkg::LINE_IDLE) && xtal_tick;
	assign tx_bit_end = xtal_tick && (tx_cnt >= period - serial_rate_pkg::PERIOD_ONE);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_cnt <= '0;
		end else if (tx_state == serial_rate_pkg::LINE_IDLE || tx_bit_end) begin
			tx_cnt <= '0;
		end else if (xtal_tick) begin
			tx_cnt <= tx_cnt + serial_rate_pkg::PERIOD_ONE;
		end
	end

	// Start, eight data bits LSB first, stop; no parity
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= serial_rate_pkg::LINE_IDLE;
			tx_bit <= '0;
			tx_shift <= '0;
			txd <= 1'h1;
		end else begin
			case (tx_state)
				serial_rate_pkg::LINE_IDLE: begin
					if (fifo_out_valid && xtal_tick) begin
						tx_shift <= fifo_out_data;
						txd <= 1'h0;
						tx_state <= serial_rate_pkg::LINE_START;
					end
				end
				serial_rate_pkg::LINE_START: begin
					if (tx_bit_end) begin
						txd <= tx_shift[0];
						tx_bit <= '0;
						tx_state <= serial_rate_pkg::LINE_DATA;
					end
				end
				serial_rate_pkg::LINE_DATA: begin
					if (tx_bit_end) begin
						if (int'(tx_bit) == serial_rate_pkg::DATA_BITS - 1) begin
							txd <= 1'h1;
							tx_state <= serial_rate_pkg::LINE_STOP;
						end else begin
							tx_shift <= {1'h0, tx_shift[7:1]};
							txd <= tx_shift[1];
							tx_bit <= tx_bit + 3'h1;
						end
					end
				end
				serial_rate_pkg::LINE_STOP: begin
					if (tx_bit_end) begin
						tx_state <= serial_rate_pkg::LINE_IDLE;
					end
				end
				default: tx_state <= serial_rate_pkg::LINE_IDLE;
			endcase
		end
	end

	// Bit ends seen in the current frame, for checking only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_bits <= '0;
		end else if (tx_state == serial_rate_pkg::LINE_IDLE) begin
			frame_bits <= '0;
		end else if (tx_bit_end) begin
			frame_bits <= frame_bits + 4'h1;
		end
	end

	start_bit_a: assert property (tx_state == serial_rate_pkg::LINE_IDLE && fifo_out_valid && xtal_tick
		|=> !txd && tx_state == serial_rate_pkg::LINE_START)
		else $error("start bit not sent");
	stop_bit_a: assert property (tx_state == serial_rate_pkg::LINE_STOP |-> txd)
		else $error("stop bit not high");
	frame_len_a: assert property (tx_state == serial_rate_pkg::LINE_STOP && tx_bit_end
		|-> int'(frame_bits) == serial_rate_pkg::FRAME_BIT_ENDS)
		else $error("frame is not ten bits long");

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_meta <= 1'h1;
			rx_sync <= 1'h1;
		end else begin
			rx_meta <= rxd;
			rx_sync <= rx_meta;
		end
	end

	// Half a period after the start edge, then whole periods: samples fall mid-bit
	assign rx_step = xtal_tick && ((rx_state == serial_rate_pkg::LINE_START)
		? (rx_cnt >= (period >> 1)) : (rx_cnt >= period - serial_rate_pkg::PERIOD_ONE));
	assign rx_done = rx_step && rx_state == serial_rate_pkg::LINE_STOP;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_cnt <= '0;
		end else if (rx_state == serial_rate_pkg::LINE_IDLE || rx_step) begin
			rx_cnt <= '0;
		end else if (xtal_tick) begin
			rx_cnt <= rx_cnt + serial_rate_pkg::PERIOD_ONE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state <= serial_rate_pkg::LINE_IDLE;
			rx_bit <= '0;
			rx_shift <= '0;
		end else begin
			case (rx_state)
				serial_rate_pkg::LINE_IDLE: begin
					if (!rx_sync) begin
						rx_state <= serial_rate_pkg::LINE_START;
					end
				end
				serial_rate_pkg::LINE_START: begin
					if (rx_step) begin
						rx_bit <= '0;
						rx_state <= rx_sync ? serial_rate_pkg::LINE_IDLE : serial_rate_pkg::LINE_DATA;
					end
				end
				serial_rate_pkg::LINE_DATA: begin
					if (rx_step) begin
						rx_shift <= {rx_sync, rx_shift[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (int'(rx_bit) == serial_rate_pkg::DATA_BITS - 1) begin
							rx_state <= serial_rate_pkg::LINE_STOP;
						end
					end
				end
				serial_rate_pkg::LINE_STOP: begin
					if (rx_step) begin
						rx_state <= serial_rate_pkg::LINE_IDLE;
					end
				end
				default: rx_state <= serial_rate_pkg::LINE_IDLE;
			endcase
		end
	end

	// Newest byte overwrites; flags are set ahead of any clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_data <= '0;
			rx_valid <= 1'h0;
			rx_overrun <= 1'h0;
			rx_frame_err <= 1'h0;
		end else begin
			if (rx_done) begin
				rx_data <= rx_shift;
				rx_valid <= 1'h1;
			end else if (rx_read) begin
				rx_valid <= 1'h0;
			end
			if (rx_done && rx_valid && !rx_read) begin
				rx_overrun <= 1'h1;
			end else if (stat_write && hwdata[serial_rate_pkg::ST_OVERRUN]) begin
				rx_overrun <= 1'h0;
			end
			if (rx_done && !rx_sync) begin
				rx_frame_err <= 1'h1;
			end else if (stat_write && hwdata[serial_rate_pkg::ST_FRAME_ERR]) begin
				rx_frame_err <= 1'h0;
			end
		end
	end
endmodule // serial_host_link

// ===== verif/serial_host_model.sv
// Behavioural host serial port: receives the device's txd and drives its rxd.
// Assumes the bench retunes it after every rate change; all times are in nanoseconds.
`timescale 1ns/1ps

module serial_host_model (
	input wire logic txd,
	output logic rxd
);
	real bit_ns = 1000.0;
	real t_fall = 0.0;
	real low_ns = 0.0;
	logic rose = 1'b1;
	logic frame_ok = 1'b1;
	logic [7:0] shift = 8'h00;
	logic [7:0] got_q[$];

	initial rxd = 1'b1;

	// ----------------------------------------
	// Port speed
	// ----------------------------------------
	// One crystal tick is 1/27.12 MHz; the host follows a new setting only when the bench calls tune
	task automatic tune(input int ticks);
		bit_ns = ticks * 1000.0 / 27.12;
	endtask

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	always begin
		@(negedge txd);
		t_fall = $realtime;
		rose = 1'b0;
		#(bit_ns / 2.0);
		frame_ok = frame_ok & ~txd;
		for (int i = 0; i < 8; i++) begin
			#(bit_ns);
			shift[i] = txd;
		end
		#(bit_ns);
		frame_ok = frame_ok & txd;
		got_q.push_back(shift);
	end

	// Length of the first low run of a frame
	always @(posedge txd) begin
		if (!rose) begin
			low_ns = $realtime - t_fall;
			rose = 1'b1;
		end
	end

	// ----------------------------------------
	// Send side
	// ----------------------------------------
	// Start, data LSB first, stop, one idle bit; a low stop only when asked
	task automatic send(input logic [7:0] d, input logic stop);
		rxd = 1'b0;
		#(bit_ns);
		for (int i = 0; i < 8; i++) begin
			rxd = d[i];
			#(bit_ns);
		end
		rxd = stop;
		#(bit_ns);
		rxd = 1'b1;
		#(bit_ns);
	endtask
endmodule // serial_host_model

// ===== verif/test_serial_host_baud_generator.sv
// Self-checking bench: rate register, bit timing, framing both ways and the transmit FIFO.
// Assumes serial_host_model on the serial pins and a single AHB-Lite master.
`timescale 1ns/1ps

module test_serial_host_baud_generator;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic rxd;
	logic txd;
	logic [7:0] lfsr = 8'h62;
	logic [31:0] word;
	logic [7:0] fill[6];
	logic [7:0] rates[4] = '{8'h15, 8'h1c, 8'h20, 8'h41};
	logic [7:0] std_codes[12] = '{8'hfa, 8'heb, 8'hda, 8'hcb, 8'hab, 8'h9a, 8'h7a, 8'h74, 8'h5a, 8'h3a, 8'h1c, 8'h15};
	int n_fail = 0;
	int checks = 0;

	always #2.5 hclk = ~hclk;

	serial_host_link serial_host_link_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd));

	serial_host_model serial_host_model_i (.txd(txd), .rxd(rxd));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] next_lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Bit period in crystal ticks for a rate setting
	function automatic int ticks(input logic [7:0] r);
		if (r[7:5] == 3'h0) return int'(r[4:0]) + 1;
		return (int'(r[4:0]) + 33) << (int'(r[7:5]) - 1);
	endfunction

	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		n = 0;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100000);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100000);
		rd = hrdata;
		cmp("bus response", 32'h0, {31'h0, hresp});
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_time(input string what, input real exp, input real got);
		checks++;
		if (got < exp - 12.0 || got > exp + 12.0) begin
			n_fail++;
			$display("Error %s expected %0.1f seen %0.1f", what, exp, got);
		end
	endtask

	// Waits for the host to collect one character, then compares it
	task automatic take(input logic [7:0] exp);
		for (int n = 0; n < 30000 && serial_host_model_i.got_q.size() == 0; n++) @(posedge hclk);
		cmp("tx byte", {24'h0, exp},
			serial_host_model_i.got_q.size() > 0 ? {24'h0, serial_host_model_i.got_q.pop_front()} : 32'hx);
	endtask

	task automatic close_out();
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		bus(serial_rate_pkg::RATE_ADDR, 1'b0, 32'h0, word);
		cmp("rate reset", 32'h0000007a, word);
		bus(8'h40, 1'b1, 32'hffffffff, word);
		bus(8'h40, 1'b0, 32'h0, word);
		cmp("unmapped", 32'h0, word);
		foreach (std_codes[i]) begin
			lfsr = next_lfsr(lfsr);
			bus(serial_rate_pkg::RATE_ADDR, 1'b1, {lfsr, lfsr, lfsr, std_codes[i]}, word);
			bus(serial_rate_pkg::RATE_ADDR, 1'b0, 32'h0, word);
			cmp("rate readback", {24'h0, std_codes[i]}, word);
		end
		foreach (rates[i]) begin
			bus(serial_rate_pkg::RATE_ADDR, 1'b1, {24'h0, rates[i]}, word);
			serial_host_model_i.tune(ticks(rates[i]));
			bus(serial_rate_pkg::TX_ADDR, 1'b1, 32'h0, word);
			take(8'h00);
			cmp_time("zero run", 9.0 * ticks(rates[i]) * 1000.0 / 27.12, serial_host_model_i.low_ns);
			lfsr = next_lfsr(lfsr);
			bus(serial_rate_pkg::TX_ADDR, 1'b1, {24'h0, lfsr}, word);
			take(lfsr);
			lfsr = next_lfsr(lfsr);
			serial_host_model_i.send(lfsr, 1'b1);
			bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
			cmp("rx status", 32'h1, word & 32'h7);
			bus(serial_rate_pkg::RX_ADDR, 1'b0, 32'h0, word);
			cmp("rx byte", {24'h0, lfsr}, word);
		end
		// Low stop bit: byte still delivered, error flag sticky until cleared
		serial_host_model_i.send(8'ha5, 1'b0);
		bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
		cmp("frame error", 32'h5, word & 32'h7);
		bus(serial_rate_pkg::RX_ADDR, 1'b0, 32'h0, word);
		cmp("rx byte", 32'h000000a5, word);
		bus(serial_rate_pkg::STAT_ADDR, 1'b1, 32'h4, word);
		bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
		cmp("error cleared", 32'h0, word & 32'h7);
		// Fill the FIFO until it stalls the bus, then drain it in order
		bus(serial_rate_pkg::RATE_ADDR, 1'b1, 32'h00000015, word);
		serial_host_model_i.tune(ticks(8'h15));
		foreach (fill[i]) begin
			lfsr = next_lfsr(lfsr);
			fill[i] = lfsr;
			bus(serial_rate_pkg::TX_ADDR, 1'b1, {24'h0, lfsr}, word);
		end
		bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
		cmp("fifo full", 32'h18, word & 32'h18);
		foreach (fill[i]) take(fill[i]);
		bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
		cmp("fifo drained", 32'h0, word & 32'h8);
		cmp("frame shape", 32'h1, {31'h0, serial_host_model_i.frame_ok});
		// Two bytes left unread: the second overwrites and flags overrun until cleared
		lfsr = next_lfsr(lfsr);
		serial_host_model_i.send(lfsr, 1'b1);
		serial_host_model_i.send(~lfsr, 1'b1);
		bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
		cmp("overrun", 32'h3, word & 32'h1f);
		bus(serial_rate_pkg::RX_ADDR, 1'b0, 32'h0, word);
		cmp("rx byte", {24'h0, ~lfsr}, word);
		bus(serial_rate_pkg::STAT_ADDR, 1'b1, 32'h2, word);
		bus(serial_rate_pkg::STAT_ADDR, 1'b0, 32'h0, word);
		cmp("overrun cleared", 32'h0, word & 32'h1f);
		// Reset in mid-run brings back the default rate
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(serial_rate_pkg::RATE_ADDR, 1'b0, 32'h0, word);
		cmp("rate after reset", 32'h0000007a, word);
		close_out();
	end

	initial begin
		repeat (90000) @(posedge hclk);
		n_fail++;
		close_out();
	end
endmodule // test_serial_host_baud_generator
